// ### hw/wrx_cfg_pkg.sv
// constants and types of the wakeup receiver serial configuration block
// assumes a 40 MHz system clock and a host that drives the serial link
//
// Functional notes
// - port is write only over select, clock and data; nothing reads back
// - bits shift into an 8 bit latch; two low bits address, six data
// - select falling edge decodes address and loads one six bit register
// - channel enable bits power channels; all default to one
// - regulator enable bit, one turns regulator on; defaults to one
// - rotator bits pick connection mode 1, 2, 3 or shorted inputs
// - each connection mode maps antennas onto channels in fixed rotation
// - meter select picks channel 1, 2, 3, or bandgap or wakeup
// - pin mode bits give high impedance, analog or digital strength pin
// - strength pin stays high impedance while select is low
// - attenuate bit switches damping resistors across all channel inputs
// - wakeup output set by pattern, power on or generator; clear forces high while diag is off
// - diag enable puts the selected test signal on the wakeup pin
// - diag select gives data or wakeup of the meter selected channel
// - step select bit picks high or low strength step; defaults to one
// - periodic generator raises artificial wakeup every two hours
// - wakeup output high during reset, asserted low right after it
// - periodic wakeup timed by counting the 32 kHz oscillator
package wrx_cfg_pkg;

  localparam logic [1:0] ADDR_POWER = 2'h0;
  localparam logic [1:0] ADDR_METER = 2'h1;
  localparam logic [1:0] ADDR_DIAG  = 2'h2;
  localparam logic [1:0] ADDR_CORR  = 2'h3;

  localparam int CHAN_EN_LSB   = 0;
  localparam int REG_EN_BIT    = 3;
  localparam int ROT_LSB       = 4;
  localparam int METER_SEL_LSB = 0;
  localparam int PIN_MODE_LSB  = 2;
  localparam int ATTEN_BIT     = 4;
  localparam int ALERT_CLR_BIT = 5;
  localparam int DIAG_EN_BIT   = 0;
  localparam int DIAG_SEL_LSB  = 1;
  localparam int SPARE_BIT     = 3;
  localparam int STEP_BIT      = 4;
  localparam int GEN_EN_BIT    = 5;

  localparam logic [5:0] POWER_RST = 6'h0f;
  localparam logic [5:0] METER_RST = 6'h00;
  localparam logic [5:0] DIAG_RST  = 6'h10;

  localparam int OSC_HZ         = 32768;
  localparam int ALERT_PERIOD_S = 7200;
  localparam int ALERT_EDGES    = ALERT_PERIOD_S * OSC_HZ;

  localparam int SYNC_WAKE = 0;
  localparam int SYNC_DATA = 3;
  localparam int SYNC_OSC  = 6;
  localparam int SYNC_SEL  = 7;
  localparam int SYNC_FULL = 8;
  localparam int SYNC_N    = 9;

  localparam logic [1:0] DIAG_DATA = 2'h0;
  localparam logic [1:0] DIAG_WAKE = 2'h1;
  localparam logic [1:0] METER_REF = 2'h3;

  typedef struct packed {
    logic [5:0] data;
    logic [1:0] addr;
  } wrx_frame_t;

  typedef logic [2:0][1:0] wrx_route_t;

  typedef enum logic [1:0] {
    WRX_PIN_HIZ     = 2'h0,
    WRX_PIN_ANALOG  = 2'h1,
    WRX_PIN_DIGITAL = 2'h2,
    WRX_PIN_UNUSED  = 2'h3
  } wrx_pin_mode_t;

  typedef enum logic [1:0] {
    WRX_ROT_MODE1 = 2'h0,
    WRX_ROT_MODE3 = 2'h1,
    WRX_ROT_MODE2 = 2'h2,
    WRX_ROT_SHORT = 2'h3
  } wrx_rot_t;

endpackage

// ### hw/wrx_cfg.sv
// serial configuration front end of the three channel wakeup receiver
// assumes the serial clock stands still outside frames and the analog
// chains deliver wake, data and oscillator levels asynchronously
`timescale 1ns/100ps
module wrx_cfg #(
  parameter int ALERT_EDGES = wrx_cfg_pkg::ALERT_EDGES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic                    serial_clock_in,
  input  wire logic                    select_latch,
  input  wire logic                    serial_data_in,
  input  wire logic                    osc_32k,
  input  wire logic [2:0]              chan_wake_in,
  input  wire logic [2:0]              chan_data_in,
  output logic [2:0]                   chan_enable,
  output logic                         regulator_enable,
  output wrx_cfg_pkg::wrx_route_t      ant_route,
  output logic                         inputs_shorted,
  output logic                         input_attenuate,
  output logic                         strength_step_sel,
  output logic [1:0]                   meter_src,
  output logic                         strength_analog_en,
  output logic                         strength_out,
  output logic                         strength_oe,
  output logic                         wake_n,
  output logic [5:0]                   corr_cfg_data,
  output logic                         corr_cfg_strobe
);

  localparam int CW = $clog2(ALERT_EDGES);

  // antenna feeding a channel in a given connection mode
  function automatic logic [1:0] route_ant(input logic [1:0] rot,
                                           input int chan);
    int sh;
    sh = 0;
    if (rot == wrx_cfg_pkg::WRX_ROT_MODE2) begin
      sh = 1;
    end else if (rot == wrx_cfg_pkg::WRX_ROT_MODE3) begin
      sh = 2;
    end
    return 2'((chan + sh) % 3);
  endfunction

  // one of three channel levels, or a fallback for the reference code
  function automatic logic pick_chan(input logic [2:0] v,
                                     input logic [1:0] sel,
                                     input logic       other);
    logic r;
    r = other;
    if (sel != wrx_cfg_pkg::METER_REF) begin
      r = v[sel];
    end
    return r;
  endfunction

  // ---------------- link domain ----------------
  logic [2:0]              bit_cnt_reg;
  logic                    full_reg;
  logic [6:0]              shift_reg;
  wrx_cfg_pkg::wrx_frame_t frame_hold_reg;

  // bit count ends with the frame: select low clears it
  always_ff @(posedge serial_clock_in or negedge select_latch) begin
    if (!select_latch) begin
      bit_cnt_reg <= 3'h0;
      full_reg    <= 1'b0;
    end else if (!full_reg) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        full_reg <= 1'b1;
      end
    end
  end

  // lsb arrives first, so shift toward bit 0
  always_ff @(posedge serial_clock_in) begin
    if (select_latch && !full_reg) begin
      shift_reg <= {serial_data_in, shift_reg[6:1]};
      if (bit_cnt_reg == 3'h7) begin
        frame_hold_reg <= {serial_data_in, shift_reg};
      end
    end
  end

  // ---------------- system domain ----------------
  logic [wrx_cfg_pkg::SYNC_N-1:0] in_raw;
  logic [wrx_cfg_pkg::SYNC_N-1:0] s1_reg;
  logic [wrx_cfg_pkg::SYNC_N-1:0] s2_reg;
  logic [wrx_cfg_pkg::SYNC_N-1:0] s3_reg;
  logic [wrx_cfg_pkg::SYNC_N-1:0] filt_reg;
  logic [wrx_cfg_pkg::SYNC_N-1:0] filt_d_reg;

  assign in_raw = {full_reg, select_latch, osc_32k,
                   chan_data_in, chan_wake_in};

  // a level counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      filt_reg   <= '0;
      filt_d_reg <= '0;
    end else begin
      s1_reg     <= in_raw;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      filt_reg   <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      filt_d_reg <= filt_reg;
    end
  end

  logic                    frame_done;
  logic                    osc_rise;
  logic                    sel_high;
  logic [2:0]              wake_lv;
  logic [2:0]              data_lv;
  wrx_cfg_pkg::wrx_frame_t fr;

  // full drops with select, so its fall marks the end of a whole frame;
  // the hold register is quiet then since the serial clock is stopped
  assign frame_done = filt_d_reg[wrx_cfg_pkg::SYNC_FULL]
                      & ~filt_reg[wrx_cfg_pkg::SYNC_FULL];
  assign osc_rise   = filt_reg[wrx_cfg_pkg::SYNC_OSC]
                      & ~filt_d_reg[wrx_cfg_pkg::SYNC_OSC];
  assign sel_high   = filt_reg[wrx_cfg_pkg::SYNC_SEL];
  assign wake_lv    = filt_reg[wrx_cfg_pkg::SYNC_WAKE +: 3];
  assign data_lv    = filt_reg[wrx_cfg_pkg::SYNC_DATA +: 3];
  assign fr         = frame_hold_reg;

  logic [5:0] pwr_reg;
  logic [5:0] meter_reg;
  logic [5:0] diag_reg;

  // no read path exists; registers only take writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pwr_reg   <= wrx_cfg_pkg::POWER_RST;
      meter_reg <= wrx_cfg_pkg::METER_RST;
      diag_reg  <= wrx_cfg_pkg::DIAG_RST;
    end else if (frame_done) begin
      unique case (fr.addr)
        wrx_cfg_pkg::ADDR_POWER: pwr_reg   <= fr.data;
        wrx_cfg_pkg::ADDR_METER: meter_reg <= fr.data;
        wrx_cfg_pkg::ADDR_DIAG:  diag_reg  <= fr.data;
        wrx_cfg_pkg::ADDR_CORR: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      corr_cfg_strobe <= 1'b0;
      corr_cfg_data   <= 6'h00;
    end else begin
      corr_cfg_strobe <= frame_done
                         && fr.addr == wrx_cfg_pkg::ADDR_CORR;
      if (frame_done && fr.addr == wrx_cfg_pkg::ADDR_CORR) begin
        corr_cfg_data <= fr.data;
      end
    end
  end

  logic [1:0] rot;
  logic [1:0] msel;
  logic [1:0] pmode;
  logic [1:0] dsel;
  logic       diag_en;
  logic       alert_clr;

  assign rot       = pwr_reg[wrx_cfg_pkg::ROT_LSB +: 2];
  assign msel      = meter_reg[wrx_cfg_pkg::METER_SEL_LSB +: 2];
  assign pmode     = meter_reg[wrx_cfg_pkg::PIN_MODE_LSB +: 2];
  assign dsel      = diag_reg[wrx_cfg_pkg::DIAG_SEL_LSB +: 2];
  assign diag_en   = diag_reg[wrx_cfg_pkg::DIAG_EN_BIT];
  assign alert_clr = meter_reg[wrx_cfg_pkg::ALERT_CLR_BIT];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      chan_enable       <= wrx_cfg_pkg::POWER_RST[2:0];
      regulator_enable  <= wrx_cfg_pkg::POWER_RST[wrx_cfg_pkg::REG_EN_BIT];
      inputs_shorted    <= 1'b0;
      input_attenuate   <= 1'b0;
      strength_step_sel <= wrx_cfg_pkg::DIAG_RST[wrx_cfg_pkg::STEP_BIT];
    end else begin
      chan_enable       <= pwr_reg[wrx_cfg_pkg::CHAN_EN_LSB +: 3];
      regulator_enable  <= pwr_reg[wrx_cfg_pkg::REG_EN_BIT];
      inputs_shorted    <= rot == wrx_cfg_pkg::WRX_ROT_SHORT;
      input_attenuate   <= meter_reg[wrx_cfg_pkg::ATTEN_BIT];
      strength_step_sel <= diag_reg[wrx_cfg_pkg::STEP_BIT];
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_route
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          ant_route[gc] <= 2'(gc);
        end else begin
          ant_route[gc] <= route_ant(rot, gc);
        end
      end
    end
  endgenerate

  // periodic artificial wakeup from the oscillator
  logic [CW-1:0] gen_cnt_reg;
  logic          gen_pulse_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b || !diag_reg[wrx_cfg_pkg::GEN_EN_BIT]) begin
      gen_cnt_reg   <= '0;
      gen_pulse_reg <= 1'b0;
    end else begin
      gen_pulse_reg <= 1'b0;
      if (osc_rise) begin
        if (gen_cnt_reg == CW'(ALERT_EDGES - 1)) begin
          gen_cnt_reg   <= '0;
          gen_pulse_reg <= 1'b1;
        end else begin
          gen_cnt_reg <= gen_cnt_reg + CW'(1);
        end
      end
    end
  end

  // alert latch; set at reset for the power-on wakeup, clear level wins
  logic alert_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      alert_reg <= 1'b1;
    end else if (alert_clr) begin
      alert_reg <= 1'b0;
    end else if ((|wake_lv) || gen_pulse_reg) begin
      alert_reg <= 1'b1;
    end
  end

  logic test_sig;
  logic pin_sig;

  always_comb begin
    test_sig = 1'b1;
    if (dsel == wrx_cfg_pkg::DIAG_DATA) begin
      test_sig = pick_chan(data_lv, msel, 1'b0);
    end else if (dsel == wrx_cfg_pkg::DIAG_WAKE) begin
      test_sig = ~pick_chan(wake_lv, msel, alert_reg);
    end
    pin_sig = diag_en ? test_sig : ~alert_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wake_n <= 1'b1;
    end else begin
      wake_n <= pin_sig;
    end
  end

  // strength pin; selection via meter bits, reference code gives bandgap
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meter_src          <= 2'h0;
      strength_analog_en <= 1'b0;
      strength_oe        <= 1'b0;
      strength_out       <= 1'b1;
    end else begin
      meter_src          <= msel;
      strength_analog_en <= sel_high
                            && pmode == wrx_cfg_pkg::WRX_PIN_ANALOG;
      strength_oe        <= sel_high
                            && pmode == wrx_cfg_pkg::WRX_PIN_DIGITAL;
      strength_out       <= (msel == wrx_cfg_pkg::METER_REF && diag_en)
                            ? ~alert_reg : pin_sig;
    end
  end

  // ---------------- checks ----------------
  a_pin_hiz_sel: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !sel_high |=> !strength_oe && !strength_analog_en)
    else $error("strength pin driven while select low");

  a_frame_commit: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    frame_done && fr.addr == wrx_cfg_pkg::ADDR_POWER
    |=> pwr_reg == $past(fr.data) && $stable(meter_reg)
        && $stable(diag_reg))
    else $error("power frame not committed alone");

  a_corr_pass: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    frame_done && fr.addr == wrx_cfg_pkg::ADDR_CORR
    |=> corr_cfg_strobe && corr_cfg_data == $past(fr.data)
        && $stable(pwr_reg))
    else $error("correlator frame not passed on");

  a_clear_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    alert_clr && !diag_en ##1 alert_clr && !diag_en |=> wake_n)
    else $error("wakeup pin low while clear held");

  a_wake_sets: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (|wake_lv) && !alert_clr ##1 !alert_clr && !diag_en
    |=> !wake_n)
    else $error("channel wakeup not shown on pin");

  a_reset_high: assert property (
    @(posedge clk_sys)
    !rst_b |=> wake_n)
    else $error("wakeup pin low during reset");

  a_por_wake: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(rst_b) |-> wake_n ##1 !wake_n)
    else $error("no power-on wakeup after reset");

  a_gen_off: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !diag_reg[wrx_cfg_pkg::GEN_EN_BIT] |=> !gen_pulse_reg
                                          && gen_cnt_reg == '0)
    else $error("generator active while off");

  a_route_mode2: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    rot == wrx_cfg_pkg::WRX_ROT_MODE2
    |=> ant_route == {2'h0, 2'h2, 2'h1})
    else $error("mode 2 routing wrong");

  a_diag_data: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    diag_en && dsel == wrx_cfg_pkg::DIAG_DATA && msel == 2'h1
    |=> wake_n == $past(data_lv[1]))
    else $error("diag data of channel 2 not on pin");

  a_corr_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    corr_cfg_strobe |=> !corr_cfg_strobe)
    else $error("correlator strobe longer than one cycle");

  a_short_code: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    rot == wrx_cfg_pkg::WRX_ROT_SHORT |=> inputs_shorted)
    else $error("inputs not shorted for rotator code 3");

  a_pin_analog: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_high && pmode == wrx_cfg_pkg::WRX_PIN_ANALOG
    |=> strength_analog_en && !strength_oe)
    else $error("strength pin not analog in analog mode");

endmodule

// ### verif/wrx_cfg_host.sv
// host model that drives the write only serial configuration link
// assumes the caller spaces frames; serial clock stands still between them
`timescale 1ns/100ps
module wrx_cfg_host (
  output logic serial_clock_in,
  output logic select_latch,
  output logic serial_data_in
);
  initial begin
    serial_clock_in = 1'b0;
    select_latch    = 1'b0;
    serial_data_in  = 1'b0;
  end

  // select held high for the whole frame
  task automatic open_frame();
    select_latch = 1'b1;
    #30;
  endtask

  // lsb first, data set up half a period before each rising edge
  task automatic shift(input logic [7:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in = f[i];
      #24 serial_clock_in = 1'b1;
      #24 serial_clock_in = 1'b0;
    end
  endtask

  // released data line shows the inverse of its last value
  task automatic close_frame();
    #120 select_latch = 1'b0;
    serial_data_in = ~serial_data_in;
    #250;
  endtask

  task automatic send(input logic [7:0] f, input int n);
    open_frame();
    shift(f, n);
    close_frame();
  endtask
endmodule

// ### verif/tb_wakeup_rx_serial_config.sv
// self checking bench for the wakeup receiver serial configuration block
// assumes the host model wrx_cfg_host and a 40 MHz system clock
`timescale 1ns/100ps
module tb_wakeup_rx_serial_config;
  logic                    clk_sys;
  logic                    rst_b;
  logic                    serial_clock_in;
  logic                    select_latch;
  logic                    serial_data_in;
  logic                    osc_32k;
  logic [2:0]              chan_wake_in;
  logic [2:0]              chan_data_in;
  logic [2:0]              chan_enable;
  logic                    regulator_enable;
  wrx_cfg_pkg::wrx_route_t ant_route;
  logic                    inputs_shorted;
  logic                    input_attenuate;
  logic                    strength_step_sel;
  logic [1:0]              meter_src;
  logic                    strength_analog_en;
  logic                    strength_out;
  logic                    strength_oe;
  logic                    wake_n;
  logic [5:0]              corr_cfg_data;
  logic                    corr_cfg_strobe;
  int                      num_errors;
  int                      samples_checked;
  int                      strobe_cnt;
  int                      seed;
  logic [5:0]              d;
  logic [5:0]              p;
  logic [3:0]              osc_cnt;

  wrx_cfg #(.ALERT_EDGES(8)) wrx_cfg_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .serial_clock_in(serial_clock_in),
    .select_latch(select_latch), .serial_data_in(serial_data_in),
    .osc_32k(osc_32k), .chan_wake_in(chan_wake_in),
    .chan_data_in(chan_data_in), .chan_enable(chan_enable),
    .regulator_enable(regulator_enable), .ant_route(ant_route),
    .inputs_shorted(inputs_shorted), .input_attenuate(input_attenuate),
    .strength_step_sel(strength_step_sel), .meter_src(meter_src),
    .strength_analog_en(strength_analog_en), .strength_out(strength_out),
    .strength_oe(strength_oe), .wake_n(wake_n),
    .corr_cfg_data(corr_cfg_data), .corr_cfg_strobe(corr_cfg_strobe)
  );

  wrx_cfg_host wrx_cfg_host_inst (
    .serial_clock_in(serial_clock_in), .select_latch(select_latch),
    .serial_data_in(serial_data_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // oscillator stand-in, 32 system cycles a period
  initial begin
    osc_32k = 1'b0;
    osc_cnt = 4'h0;
  end
  always @(negedge clk_sys) begin
    osc_cnt <= osc_cnt + 4'h1;
    if (osc_cnt == 4'hf) begin
      osc_32k <= ~osc_32k;
    end
  end

  // one count per correlator strobe pulse
  always @(negedge clk_sys) begin
    if (corr_cfg_strobe === 1'b1) begin
      strobe_cnt <= strobe_cnt + 1;
    end
  end

  // antenna index per channel, channel 3 first
  function automatic wrx_cfg_pkg::wrx_route_t route_exp(input logic [1:0] r);
    case (r)
      2'h2:    return 6'h09;
      2'h1:    return 6'h12;
      default: return 6'h24;
    endcase
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [5:0] v);
    wrx_cfg_host_inst.send({v, a}, 8);
    @(negedge clk_sys);
  endtask

  task automatic wait_wake(input logic lvl, input int n);
    for (int i = 0; i < n && wake_n !== lvl; i++) @(negedge clk_sys);
    check("wake_n wait", wake_n, lvl);
    if (wake_n !== lvl) begin
      conclude();
    end
  endtask

  task automatic clear_alert();
    wr(2'h1, 6'h20);
    check("wake_n cleared", wake_n, 1'b1);
    wr(2'h1, 6'h00);
  endtask

  task automatic hold_wake(input logic [2:0] w);
    chan_wake_in = w;
    repeat (8) @(negedge clk_sys);
  endtask

  initial begin
    seed = 32'h37c9693b;
    num_errors = 0;
    samples_checked = 0;
    strobe_cnt = 0;
    rst_b = 1'b0;
    chan_wake_in = 3'h0;
    chan_data_in = 3'h0;
    repeat (15) @(negedge clk_sys);
    check("wake_n in reset", wake_n, 1'b1);
    check("power rst", {inputs_shorted, regulator_enable, chan_enable},
          8'h0f);
    check("route rst", 8'(ant_route), 8'h24);
    check("meter rst", {strength_step_sel, input_attenuate, meter_src},
          8'h08);
    check("pin rst", {strength_out, strength_oe, strength_analog_en},
          8'h04);
    check("corr rst", {corr_cfg_strobe, corr_cfg_data}, 8'h00);
    @(negedge clk_sys);
    rst_b = 1'b1;
    wait_wake(1'b0, 5);
    // wake events while clear is held are lost
    wr(2'h1, 6'h20);
    hold_wake(3'h2);
    hold_wake(3'h0);
    check("wake_n held", wake_n, 1'b1);
    wr(2'h1, 6'h00);
    check("wake_n rearmed", wake_n, 1'b1);
    hold_wake(3'h4);
    hold_wake(3'h0);
    wait_wake(1'b0, 20);
    clear_alert();
    for (int i = 0; i < 8; i++) begin
      d = 6'($random(seed));
      d[5:4] = i[1:0];
      p = d;
      wr(2'h0, d);
      check("chan_enable", chan_enable, d[2:0]);
      check("regulator", regulator_enable, d[3]);
      check("shorted", inputs_shorted, &d[5:4]);
      check("route", 8'(ant_route), 8'(route_exp(d[5:4])));
    end
    for (int i = 0; i < 4; i++) begin
      d = 6'($random(seed));
      d = {1'b0, d[4], 2'h0, i[1:0]};
      wr(2'h1, d);
      check("meter_src", meter_src, i[1:0]);
      check("attenuate", input_attenuate, d[4]);
      check("chan kept", chan_enable, p[2:0]);
    end
    // empty frame opens select only, nothing is loaded
    for (int m = 0; m < 4; m++) begin
      wr(2'h1, {2'h0, m[1:0], 2'h0});
      check("pin idle", {strength_oe, strength_analog_en}, 8'h00);
      wrx_cfg_host_inst.open_frame();
      repeat (8) @(negedge clk_sys);
      check("pin mode", {strength_oe, strength_analog_en},
            {6'h00, m == 2, m == 1});
      wrx_cfg_host_inst.close_frame();
    end
    wrx_cfg_host_inst.send({~p, 2'h0}, 7);
    check("short frame", chan_enable, p[2:0]);
    d = 6'($random(seed));
    wr(2'h3, d);
    check("corr data", corr_cfg_data, d);
    check("corr strobe", 8'(strobe_cnt), 8'h01);
    check("corr kept", chan_enable, p[2:0]);
    wr(2'h2, 6'h01); // spare bit written 0
    check("step low", strength_step_sel, 1'b0);
    for (int c = 0; c < 3; c++) begin
      wr(2'h1, 6'(c));
      chan_data_in = 3'($random(seed));
      repeat (8) @(negedge clk_sys);
      check("diag data", wake_n, chan_data_in[c]);
    end
    wr(2'h2, 6'h03);
    hold_wake(3'h3);
    check("diag wake idle", wake_n, 1'b1);
    hold_wake(3'h4);
    check("diag wake", wake_n, 1'b0);
    hold_wake(3'h0);
    wr(2'h2, 6'h10);
    check("step high", strength_step_sel, 1'b1);
    check("wake normal", wake_n, 1'b0);
    check("strength_out", strength_out, 1'b0);
    clear_alert();
    wr(2'h2, 6'h30);
    wait_wake(1'b0, 800);
    wr(2'h2, 6'h10);
    clear_alert();
    repeat (600) @(negedge clk_sys);
    check("generator off", wake_n, 1'b1);
    conclude();
  end
endmodule
